// >>> logic/pmc_counter.v
// Periodic modulo counter: prescaler, 8-bit up-counter, modulo match and interrupt.
// Assumes source clocks arrive as slow levels from other domains, sampled on clk_sys,
// and that the system gives debug and stop indications as levels on clk_sys.
//
// Operation
// - One 8-bit up-counter, comparator and prescaler give one periodic interrupt.
// - Match flag bit 7 sets on match; writing 1 clears it; reset clears.
// - Source field 6..5: 00 low-power osc, 01 external ref, 1x internal ref.
// - Writing a changed source value clears prescaler and counter.
// - Interrupt enable bit 4 gates the match flag onto the request.
// - Writing a changed prescale code clears prescaler and counter; reset gives off.
// - With source bit 0 low, codes give binary/decimal small ratios.
// - With source bit 0 high, codes give large ratios up to 200000.
// - Counter keeps running in wait mode so a match can wake it.
// - Counter keeps running in shallow stop modes; match wakes the processor.
// - Low-power osc works in both stop modes; reference clocks only shallowest.
// - With every source disabled the counter holds and cannot wake.
// - Debug mode freezes counting; resumes from held value unless reconfigured.
// - No chip pins; clocks and interrupt are internal signals.
// - Counter increments to modulo, then wraps to zero setting the match flag.
// - Modulo write clears prescaler and counter; modulo zero matches every tick.
// - Count register is read-only, writes ignored, reset clears it.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`include "pmc_defines.vh"
`default_nettype none

module pmc_counter
(
  // Clock, reset, enable
  input wire clk_sys,
  input wire srst,
  input wire clk_en,
  // Register port
  input wire [1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Source clocks from the clock generator, internal nets
  input wire low_power_osc_1khz,
  input wire external_ref_clock,
  input wire internal_ref_clock,
  // Power mode indications
  input wire debug_active,
  input wire stop_deep,
  input wire stop_shallow,
  // Interrupt and wake
  output wire irq,
  output wire wake_req
);

  // ==========================================================
  // Control registers
  reg match_flag_q;
  reg [1:0] clock_source_select_q;
  reg match_irq_enable_q;
  reg [3:0] prescale_select_q;
  reg [7:0] modulo_limit_q;
  reg [7:0] count_value_q;
  reg [17:0] presc_q;
  reg [0:0] irq_mask_q;
  reg [0:0] irq_stat_q;

  wire wr_sc = reg_wr && (reg_addr == `PMC_OFS_STATUS_CONTROL);
  wire wr_mod = reg_wr && (reg_addr == `PMC_OFS_MODULO_LIMIT);
  wire wr_irq = reg_wr && (reg_addr == `PMC_OFS_IRQ_STATUS);
  wire rd_irq = reg_rd && (reg_addr == `PMC_OFS_IRQ_STATUS);
  wire src_chg = wr_sc &&
    (reg_wdata[`PMC_BIT_SRC_HI:`PMC_BIT_SRC_LO] != clock_source_select_q);
  wire ps_chg = wr_sc && (reg_wdata[`PMC_BIT_PS_HI:`PMC_BIT_PS_LO] != prescale_select_q);
  wire restart = src_chg || ps_chg || wr_mod;

  // ==========================================================
  // Source clock synchronisers, two flops then edge detect
  // Each source is asynchronous to clk_sys; the second and third flops feed the edge detect.
  // A source must stay high and low for at least two system cycles or ticks are lost.
  wire [2:0] src_pin = {internal_ref_clock, external_ref_clock, low_power_osc_1khz};
  wire [2:0] src_rise;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_sync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      always @(posedge clk_sys)
      begin
        if (srst)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end
        else if (clk_en)
        begin
          s1_q <= src_pin[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // Idle level of every source is low, so no false edge follows reset
      assign src_rise[gi] = s2_q && !s3_q;
    end
  endgenerate

  // ==========================================================
  // Source select and availability in low-power modes
  // Shallow stop leaves every source running, so stop_shallow needs no gating here.
  // It is accepted so the power controller can drive both levels without a special case.
  reg src_tick;
  always @*
  begin
    src_tick = 1'b0;
    if (clock_source_select_q == `PMC_SRC_LPO)
      src_tick = src_rise[0];
    else if (clock_source_select_q == `PMC_SRC_EXT)
      src_tick = src_rise[1] && !stop_deep;
    else
      src_tick = src_rise[2] && !stop_deep;
  end

  // Divide ratio lookup; zero means prescaler off
  // A full table instead of a shifter: the decimal ratios are not powers of two,
  // and one flat compare against the ratio keeps the prescaler to a single adder.
  reg [17:0] div_ratio;
  always @*
  begin
    div_ratio = 18'h00000;
    if (!clock_source_select_q[0])
    begin
      case (prescale_select_q)
        4'h1:
        begin
          div_ratio = `PMC_DIV_B1;
        end
        4'h2:
        begin
          div_ratio = `PMC_DIV_B2;
        end
        4'h3:
        begin
          div_ratio = `PMC_DIV_B3;
        end
        4'h4:
        begin
          div_ratio = `PMC_DIV_B4;
        end
        4'h5:
        begin
          div_ratio = `PMC_DIV_B5;
        end
        4'h6:
        begin
          div_ratio = `PMC_DIV_B6;
        end
        4'h7:
        begin
          div_ratio = `PMC_DIV_B7;
        end
        4'h8:
        begin
          div_ratio = `PMC_DIV_B8;
        end
        4'h9:
        begin
          div_ratio = `PMC_DIV_B9;
        end
        4'ha:
        begin
          div_ratio = `PMC_DIV_B10;
        end
        4'hb:
        begin
          div_ratio = `PMC_DIV_B11;
        end
        4'hc:
        begin
          div_ratio = `PMC_DIV_B12;
        end
        4'hd:
        begin
          div_ratio = `PMC_DIV_B13;
        end
        4'he:
        begin
          div_ratio = `PMC_DIV_B14;
        end
        4'hf:
        begin
          div_ratio = `PMC_DIV_B15;
        end
        default:
        begin
          div_ratio = 18'h00000;
        end
      endcase
    end
    else
    begin
      // Large ratios serve the external reference and the internal reference at source code 11
      case (prescale_select_q)
        4'h1:
        begin
          div_ratio = `PMC_DIV_H1;
        end
        4'h2:
        begin
          div_ratio = `PMC_DIV_H2;
        end
        4'h3:
        begin
          div_ratio = `PMC_DIV_H3;
        end
        4'h4:
        begin
          div_ratio = `PMC_DIV_H4;
        end
        4'h5:
        begin
          div_ratio = `PMC_DIV_H5;
        end
        4'h6:
        begin
          div_ratio = `PMC_DIV_H6;
        end
        4'h7:
        begin
          div_ratio = `PMC_DIV_H7;
        end
        4'h8:
        begin
          div_ratio = `PMC_DIV_H8;
        end
        4'h9:
        begin
          div_ratio = `PMC_DIV_H9;
        end
        4'ha:
        begin
          div_ratio = `PMC_DIV_H10;
        end
        4'hb:
        begin
          div_ratio = `PMC_DIV_H11;
        end
        4'hc:
        begin
          div_ratio = `PMC_DIV_H12;
        end
        4'hd:
        begin
          div_ratio = `PMC_DIV_H13;
        end
        4'he:
        begin
          div_ratio = `PMC_DIV_H14;
        end
        4'hf:
        begin
          div_ratio = `PMC_DIV_H15;
        end
        default:
        begin
          div_ratio = 18'h00000;
        end
      endcase
    end
  end

  // Wait and shallow stop do not gate counting; only prescaler off, debug and source loss do
  wire run = (div_ratio != 18'h00000) && !debug_active;
  wire adv = run && src_tick;
  wire ps_out = adv && (presc_q == div_ratio - 18'h00001);
  wire cnt_match = (count_value_q == modulo_limit_q);

  // ==========================================================
  // Prescaler and counter
  // Restart wins over a tick in the same cycle so a reconfigured counter starts clean.
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      presc_q <= 18'h00000;
      count_value_q <= `PMC_RST_CNT;
    end
    else if (clk_en)
    begin
      if (restart)
      begin
        presc_q <= 18'h00000;
        count_value_q <= `PMC_RST_CNT;
      end
      else if (adv)
      begin
        presc_q <= ps_out ? 18'h00000 : presc_q + 18'h00001;
        if (ps_out)
          count_value_q <= cnt_match ? 8'h00 : count_value_q + 8'h01;
      end
    end
  end

  // ==========================================================
  // Status and control register
  wire match_evt = ps_out && cnt_match && !restart;
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      match_flag_q <= 1'b0;
      clock_source_select_q <= 2'h0;
      match_irq_enable_q <= 1'b0;
      prescale_select_q <= 4'h0;
      modulo_limit_q <= `PMC_RST_MOD;
    end
    else if (clk_en)
    begin
      // Set wins over a clear in the same cycle
      if (match_evt)
        match_flag_q <= 1'b1;
      else if (wr_sc && reg_wdata[`PMC_BIT_MATCH_FLAG])
        match_flag_q <= 1'b0;
      if (wr_sc)
      begin
        clock_source_select_q <= reg_wdata[`PMC_BIT_SRC_HI:`PMC_BIT_SRC_LO];
        match_irq_enable_q <= reg_wdata[`PMC_BIT_IRQ_EN];
        prescale_select_q <= reg_wdata[`PMC_BIT_PS_HI:`PMC_BIT_PS_LO];
      end
      if (wr_mod)
        modulo_limit_q <= reg_wdata;
    end
  end

  // ==========================================================
  // Sticky interrupt status, cleared on read, with mask
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      irq_stat_q <= 1'b0;
      irq_mask_q <= 1'b1;
    end
    else if (clk_en)
    begin
      if (match_evt)
        irq_stat_q <= 1'b1;
      else if (rd_irq || (wr_sc && reg_wdata[`PMC_BIT_MATCH_FLAG]))
        irq_stat_q <= 1'b0;
      if (wr_irq)
        irq_mask_q <= reg_wdata[0:0];
    end
  end

  // Request also drops when the match flag is cleared by software
  assign irq = match_irq_enable_q && match_flag_q && irq_stat_q[0] && irq_mask_q[0];
  assign wake_req = irq;

  // ==========================================================
  // Read data, one cycle after the strobe
  // Data returns to zero so a stale value never looks like a fresh read.
  always @(posedge clk_sys)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (clk_en)
    begin
      reg_rdata <= 8'h00;
      if (reg_rd)
      begin
        case (reg_addr)
          `PMC_OFS_STATUS_CONTROL:
            reg_rdata <= {match_flag_q, clock_source_select_q, match_irq_enable_q,
              prescale_select_q};
          `PMC_OFS_COUNT_VALUE: reg_rdata <= count_value_q;
          `PMC_OFS_MODULO_LIMIT: reg_rdata <= modulo_limit_q;
          `PMC_OFS_IRQ_STATUS: reg_rdata <= {6'h00, irq_mask_q, irq_stat_q};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// >>> logic/pmc_defines.vh
// Register offsets, field positions, reset values and divider ratios
// for the periodic modulo counter. Definitions only.
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH

// Register indexes on the plain register port
`define PMC_OFS_STATUS_CONTROL 2'h0
`define PMC_OFS_COUNT_VALUE 2'h1
`define PMC_OFS_MODULO_LIMIT 2'h2
`define PMC_OFS_IRQ_STATUS 2'h3

// Field positions in status_control
`define PMC_BIT_MATCH_FLAG 7
`define PMC_BIT_SRC_HI 6
`define PMC_BIT_SRC_LO 5
`define PMC_BIT_IRQ_EN 4
`define PMC_BIT_PS_HI 3
`define PMC_BIT_PS_LO 0

// Reset values
`define PMC_RST_SC 8'h00
`define PMC_RST_MOD 8'h00
`define PMC_RST_CNT 8'h00

// Clock source codes
`define PMC_SRC_LPO 2'h0
`define PMC_SRC_EXT 2'h1

// Prescaler divide ratios, small and large tables, each holding binary and decimal ratios
`define PMC_DIV_B1 18'h00008
`define PMC_DIV_B2 18'h00020
`define PMC_DIV_B3 18'h00040
`define PMC_DIV_B4 18'h00080
`define PMC_DIV_B5 18'h00100
`define PMC_DIV_B6 18'h00200
`define PMC_DIV_B7 18'h00400
`define PMC_DIV_B8 18'h00001
`define PMC_DIV_B9 18'h00002
`define PMC_DIV_B10 18'h00004
`define PMC_DIV_B11 18'h0000a
`define PMC_DIV_B12 18'h00010
`define PMC_DIV_B13 18'h00064
`define PMC_DIV_B14 18'h001f4
`define PMC_DIV_B15 18'h003e8
`define PMC_DIV_H1 18'h00400
`define PMC_DIV_H2 18'h00800
`define PMC_DIV_H3 18'h01000
`define PMC_DIV_H4 18'h02000
`define PMC_DIV_H5 18'h04000
`define PMC_DIV_H6 18'h08000
`define PMC_DIV_H7 18'h10000
`define PMC_DIV_H8 18'h003e8
`define PMC_DIV_H9 18'h007d0
`define PMC_DIV_H10 18'h01388
`define PMC_DIV_H11 18'h02710
`define PMC_DIV_H12 18'h04e20
`define PMC_DIV_H13 18'h0c350
`define PMC_DIV_H14 18'h186a0
`define PMC_DIV_H15 18'h30d40

`endif

// >>> dv/pmc_counter_assertions.sv
// Port checker for the periodic modulo counter.
// Assumes one clock, a synchronous active-high reset, bound to pmc_counter.
`default_nettype none
module pmc_counter_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Interrupt
  input wire logic irq,
  input wire logic wake_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Register mirrors
  logic [7:0] sc_q;
  logic [7:0] mod_q;
  logic mask_q;
  wire wr_go = clk_en && reg_wr;
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      sc_q <= 8'h00;
      mod_q <= 8'h00;
      mask_q <= 1'h1;
    end
    else if (wr_go)
    begin
      if (reg_addr == 2'h0)
        sc_q <= {1'h0, reg_wdata[6:0]};
      if (reg_addr == 2'h2)
        mod_q <= reg_wdata;
      if (reg_addr == 2'h3)
        mask_q <= reg_wdata[0];
    end
  end
  // ==========
  // Properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_rdata_quiet: assert property ((clk_en && !reg_rd) |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read");
  a_irq_wake_same: assert property (irq == wake_req)
    else $error("wake differs from irq");
  a_ie_off_quiet: assert property (!sc_q[4] |-> !irq)
    else $error("irq with enable clear");
  a_mask_off_quiet: assert property (!mask_q |-> !irq)
    else $error("irq while masked");
  a_flag_clear_off: assert property ((wr_go && reg_addr == 2'h0 && reg_wdata[7]
    && reg_wdata[3:0] == 4'h0) |=> !irq [*3])
    else $error("irq after flag clear");
  a_irq_sticky_hold: assert property ((irq && !wr_go && !(reg_rd && reg_addr == 2'h3))
    |=> irq)
    else $error("irq dropped by itself");
  a_mod_read_back: assert property ((clk_en && reg_rd && reg_addr == 2'h2)
    |=> reg_rdata == mod_q)
    else $error("modulo read back wrong");
  a_sc_read_back: assert property ((clk_en && reg_rd && reg_addr == 2'h0)
    |=> reg_rdata[6:0] == sc_q[6:0])
    else $error("control read back wrong");
endmodule
bind pmc_counter pmc_counter_assertions u_chk (.clk_sys(clk_sys), .srst(srst),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .wake_req(wake_req));
`default_nettype wire

// >>> dv/pmc_counter_bench.sv
// Self-checking bench for the periodic modulo counter.
// Assumes source clocks are slow levels, held high 3 system cycles and low at least 3.
`default_nettype none
module pmc_counter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0;
  logic srst = 1'h1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [2:0] src = 3'h0;
  logic dbg = 1'h0;
  logic stp_d = 1'h0;
  logic stp_s = 1'h0;
  logic ce = 1'h1;
  wire [7:0] reg_rdata;
  wire irq;
  wire wake_req;
  int mismatches = 0;
  int compares = 0;
  pmc_counter uut (.clk_sys(clk_sys), .srst(srst), .clk_en(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .low_power_osc_1khz(src[0]), .external_ref_clock(src[1]), .internal_ref_clock(src[2]),
    .debug_active(dbg), .stop_deep(stp_d), .stop_shallow(stp_s), .irq(irq),
    .wake_req(wake_req));
  // ==========
  // Tasks
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1;
    chk($sformatf("reg%0d", a), exp, reg_rdata);
  endtask
  // Each rising edge of a source is one tick; 3 high, 4 low keeps the sampler honest
  task automatic pulse(input int i, input int n);
    repeat (n)
    begin
      @(posedge clk_sys) src[i] <= 1'h1;
      repeat (3) @(posedge clk_sys);
      src[i] <= 1'h0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h00);
    rd(2'h3, 8'h02);
    $display("test reset done");
  endtask
  task automatic t_match;
    wr(2'h2, 8'h03);
    wr(2'h0, 8'h08);
    pulse(0, 3);
    wr(2'h1, 8'h55);
    rd(2'h1, 8'h03);
    pulse(0, 1);
    rd(2'h1, 8'h00);
    rd(2'h0, 8'h88);
    chk("irq", 8'h00, {7'h00, irq});
    wr(2'h0, 8'h18);
    chk("irq", 8'h01, {7'h00, irq});
    chk("wake", 8'h01, {7'h00, wake_req});
    wr(2'h3, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    wr(2'h3, 8'h01);
    rd(2'h3, 8'h03);
    chk("irq", 8'h00, {7'h00, irq});
    pulse(0, 4);
    chk("irq", 8'h01, {7'h00, irq});
    wr(2'h0, 8'h90);
    rd(2'h0, 8'h10);
    pulse(0, 2);
    rd(2'h1, 8'h00);
    $display("test match done");
  endtask
  task automatic t_source;
    wr(2'h0, 8'h09);
    pulse(0, 5);
    rd(2'h1, 8'h02);
    wr(2'h0, 8'h49);
    rd(2'h1, 8'h00);
    pulse(0, 2);
    pulse(2, 4);
    rd(2'h1, 8'h02);
    wr(2'h0, 8'h28);
    pulse(1, 999);
    rd(2'h1, 8'h00);
    pulse(1, 1);
    rd(2'h1, 8'h01);
    $display("test source done");
  endtask
  task automatic t_modes;
    wr(2'h0, 8'h48);
    @(posedge clk_sys) dbg <= 1'h1;
    pulse(2, 2);
    rd(2'h1, 8'h00);
    @(posedge clk_sys) dbg <= 1'h0;
    pulse(2, 1);
    rd(2'h1, 8'h01);
    @(posedge clk_sys) ce <= 1'h0;
    pulse(2, 1);
    @(posedge clk_sys) ce <= 1'h1;
    rd(2'h1, 8'h01);
    @(posedge clk_sys) stp_d <= 1'h1;
    pulse(2, 1);
    rd(2'h1, 8'h01);
    @(posedge clk_sys) stp_s <= 1'h1;
    stp_d <= 1'h0;
    pulse(2, 1);
    rd(2'h1, 8'h02);
    wr(2'h0, 8'h08);
    @(posedge clk_sys) stp_d <= 1'h1;
    pulse(0, 1);
    rd(2'h1, 8'h01);
    wr(2'h2, 8'h00);
    rd(2'h1, 8'h00);
    wr(2'h0, 8'h88);
    pulse(0, 1);
    rd(2'h0, 8'h88);
    rd(2'h1, 8'h00);
    $display("test modes done");
  endtask
  // ==========
  // Run control
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (50000) @(posedge clk_sys);
    mismatches++;
    report_and_stop();
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'h0;
    t_reset();
    t_match();
    t_source();
    t_modes();
    report_and_stop();
  end
endmodule
`default_nettype wire
